/* verilog/gesu_pkg.sv */
// Package of constants and types for the GP-IB event status unit.
`default_nettype none

package gesu_pkg;

  // ------------------------------------------------------------
  // Event flag bit positions
  // ------------------------------------------------------------
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned POWERUP_BIT = 7;
  localparam int unsigned USER_REQ_BIT = 6;
  localparam int unsigned SYNTAX_ERR_BIT = 5;
  localparam int unsigned EXEC_ERR_BIT = 4;
  localparam int unsigned DEV_FAULT_BIT = 3;
  localparam int unsigned RESP_ERR_BIT = 2;
  localparam int unsigned CTRL_REQ_BIT = 1;
  localparam int unsigned OP_DONE_BIT = 0;

  // ------------------------------------------------------------
  // Status byte bit positions and reset values
  // ------------------------------------------------------------
  localparam int unsigned MASTER_SUM_BIT = 6;
  localparam int unsigned EVENT_SUM_BIT = 5;
  localparam int unsigned RESP_PEND_BIT = 4;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_SET_ALLOWED = 8'hbd;

  // ------------------------------------------------------------
  // Response queue sizing
  // ------------------------------------------------------------
  localparam int unsigned QUEUE_BYTES = 128;
  localparam int unsigned QCNT_W = 8;

  // Remote/local state of the front panel.
  typedef enum logic [1:0] {
    GESU_LOCAL = 2'b00,
    GESU_REMOTE = 2'b01,
    GESU_LOCKOUT = 2'b10
  } gesu_panel_e;

endpackage : gesu_pkg

`default_nettype wire

/* verilog/gesu_resp_queue.sv */
// Byte counter model of the 128-byte response queue with query error detection.
`timescale 1ns/1ps
`default_nettype none

module gesu_resp_queue
  import gesu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Queue traffic.
  input wire logic push_in,
  input wire logic pop_in,
  input wire logic flush_in,
  input wire logic new_msg_in,
  input wire logic idn_extra_query_in,
  // Status.
  output logic pending_out,
  output logic resp_err_out
);

  typedef struct packed {
    logic [QCNT_W-1:0] count;
    logic err;
  } gesu_q_s;

  gesu_q_s state_q;
  gesu_q_s state_d;

  // Next state: flush on clear, error on overflow, underflow or stale data.
  always_comb
  begin
    state_d = state_q;
    state_d.err = 1'b0;
    if (flush_in)
    begin
      state_d.count = '0;
    end
    else if ((pop_in && state_q.count == '0) ||
             (push_in && state_q.count == QCNT_W'(QUEUE_BYTES)) ||
             (new_msg_in && state_q.count != '0) || idn_extra_query_in)
    begin
      state_d.count = '0; // Query error empties the queue.
      state_d.err = 1'b1;
    end
    else if (push_in && !pop_in)
    begin
      state_d.count = state_q.count + QCNT_W'(1);
    end
    else if (pop_in && !push_in)
    begin
      state_d.count = state_q.count - QCNT_W'(1);
    end
  end

  // State register.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pending_out = (state_q.count != '0);
  assign resp_err_out = state_q.err;

endmodule : gesu_resp_queue

`default_nettype wire

/* verilog/gesu_event_unit.sv */
// Standard event flags, masks, status byte and GP-IB interface command reactions.
`timescale 1ns/1ps
`default_nettype none

module gesu_event_unit
  import gesu_pkg::*;
(
  // Clock and reset; reset marks power-on.
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic power_restore_in,
  // Parser event strobes.
  input wire logic syntax_error_in,
  input wire logic terminator_in,
  input wire logic range_error_in,
  input wire logic device_fault_in,
  input wire logic op_complete_req_in,
  input wire logic actions_idle_in,
  // Common commands and queries.
  input wire logic clear_status_in,
  input wire logic flags_query_in,
  input wire logic flags_mask_write_in,
  input wire logic srq_mask_write_in,
  input wire logic [7:0] write_data_in,
  // Response queue traffic.
  input wire logic resp_push_in,
  input wire logic resp_pop_in,
  input wire logic new_msg_in,
  input wire logic idn_extra_query_in,
  // Interface commands and panel.
  input wire logic go_local_in,
  input wire logic remote_in,
  input wire logic lockout_in,
  input wire logic dev_clear_in,
  input wire logic trigger_in,
  input wire logic hold_in,
  input wire logic serial_poll_in,
  // Register read values.
  output logic [7:0] event_flags_reg_out,
  output logic [7:0] event_flags_mask_out,
  output logic [7:0] service_request_mask_out,
  output logic [7:0] status_byte_out,
  // Control outputs.
  output logic service_request_out,
  output logic discard_input_out,
  output logic input_flush_out,
  output logic measure_start_out,
  output logic keys_enabled_out,
  output logic local_key_enabled_out
);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] srq_mask;
    logic [7:0] stb;
    logic srq;
    logic rqs;
    logic discard;
    logic flush;
    logic measure;
    logic op_wait;
    gesu_panel_e panel;
    logic keys;
    logic local_key;
  } gesu_state_s;

  gesu_state_s state_q;
  gesu_state_s state_d;
  logic q_pending;
  logic q_resp_err;
  logic [7:0] set_vec;
  logic [7:0] masked;
  logic event_sum;
  logic [7:0] stb_next;
  logic mss_next;

  // ------------------------------------------------------------
  // Response queue
  // ------------------------------------------------------------

  // Queue is emptied by a device clear (dev_clear_in) or by a query error; clear status does not empty it.
  gesu_resp_queue u_queue (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .push_in(resp_push_in),
    .pop_in(resp_pop_in),
    .flush_in(dev_clear_in),
    .new_msg_in(new_msg_in),
    .idn_extra_query_in(idn_extra_query_in),
    .pending_out(q_pending),
    .resp_err_out(q_resp_err)
  );

  // ------------------------------------------------------------
  // Event sources and summaries
  // ------------------------------------------------------------

  // Collect one-cycle set requests per flag bit.
  always_comb
  begin
    set_vec = 8'h00;
    set_vec[POWERUP_BIT] = power_restore_in;
    set_vec[SYNTAX_ERR_BIT] = syntax_error_in;
    set_vec[EXEC_ERR_BIT] = range_error_in || (trigger_in && !hold_in);
    set_vec[DEV_FAULT_BIT] = device_fault_in;
    set_vec[RESP_ERR_BIT] = q_resp_err;
    set_vec[OP_DONE_BIT] = (state_q.op_wait || op_complete_req_in) && actions_idle_in;
    set_vec = set_vec & FLAG_SET_ALLOWED; // Bits 6 and 1 stay zero.
  end

  // Summary from flags gated by the enable mask, per bit.
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_W; gi++)
    begin : g_mask
      assign masked[gi] = state_q.flags[gi] & state_q.mask[gi];
    end
  endgenerate
  assign event_sum = |masked;

  // Status byte assembly and master summary.
  always_comb
  begin
    stb_next = 8'h00;
    stb_next[EVENT_SUM_BIT] = event_sum;
    stb_next[RESP_PEND_BIT] = q_pending;
    mss_next = |(stb_next & state_q.srq_mask);
    stb_next[MASTER_SUM_BIT] = mss_next;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------

  // Flag, mask, service request and panel updates.
  always_comb
  begin
    state_d = state_q;
    // Sticky flags; a set in the clear cycle survives the clear.
    if (clear_status_in || flags_query_in)
    begin
      state_d.flags = set_vec;
    end
    else
    begin
      state_d.flags = state_q.flags | set_vec;
    end
    // Masks are written only by their common commands.
    if (flags_mask_write_in)
    begin
      state_d.mask = write_data_in;
    end
    if (srq_mask_write_in)
    begin
      state_d.srq_mask = write_data_in;
    end
    // Request raised on a rising enabled summary, cleared by serial poll.
    if (mss_next && !state_q.stb[MASTER_SUM_BIT])
    begin
      state_d.rqs = 1'b1;
    end
    else if (serial_poll_in)
    begin
      state_d.rqs = 1'b0;
    end
    state_d.srq = state_d.rqs;
    state_d.stb = stb_next;
    // Discard parser input from a syntax error up to the terminator.
    if (syntax_error_in)
    begin
      state_d.discard = 1'b1;
    end
    else if (terminator_in || dev_clear_in)
    begin
      state_d.discard = 1'b0;
    end
    state_d.flush = dev_clear_in;
    state_d.measure = trigger_in && hold_in; // One pulse per trigger while hold is set.
    // Wait for outstanding actions after an operation complete request.
    if (set_vec[OP_DONE_BIT])
    begin
      state_d.op_wait = 1'b0;
    end
    else if (op_complete_req_in)
    begin
      state_d.op_wait = 1'b1;
    end
    // Remote, local and lockout panel state.
    if (lockout_in)
    begin
      state_d.panel = GESU_LOCKOUT;
    end
    else if (go_local_in)
    begin
      state_d.panel = GESU_LOCAL;
    end
    else if (remote_in && state_q.panel == GESU_LOCAL)
    begin
      state_d.panel = GESU_REMOTE;
    end
    unique case (state_d.panel)
      GESU_LOCAL:
      begin
        state_d.keys = 1'b1;
        state_d.local_key = 1'b1;
      end
      GESU_REMOTE:
      begin
        state_d.keys = 1'b0;
        state_d.local_key = 1'b1;
      end
      GESU_LOCKOUT:
      begin
        state_d.keys = 1'b0;
        state_d.local_key = 1'b0;
      end
      default:
      begin
        state_d.keys = 1'b1;
        state_d.local_key = 1'b1;
      end
    endcase
  end

  // State register; reset is power-on and sets the power-up flag.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= '0;
      state_q.flags <= FLAGS_RESET;
      state_q.mask <= MASK_RESET;
      state_q.srq_mask <= SRQ_MASK_RESET;
      state_q.panel <= GESU_LOCAL;
      state_q.keys <= 1'b1;
      state_q.local_key <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign event_flags_reg_out = state_q.flags;
  assign event_flags_mask_out = state_q.mask;
  assign service_request_mask_out = state_q.srq_mask;
  assign status_byte_out = state_q.stb;
  assign service_request_out = state_q.srq;
  assign discard_input_out = state_q.discard;
  assign input_flush_out = state_q.flush;
  assign measure_start_out = state_q.measure;
  assign keys_enabled_out = state_q.keys;
  assign local_key_enabled_out = state_q.local_key;

endmodule : gesu_event_unit

`default_nettype wire

/* verification/gesu_event_monitor.sv */
// Concurrent checks on the ports of the event status unit.
`timescale 1ns/1ps
`default_nettype none

module gesu_event_monitor
  import gesu_pkg::*;
(
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Watched inputs.
  input wire logic syntax_error_in,
  input wire logic range_error_in,
  input wire logic device_fault_in,
  input wire logic power_restore_in,
  input wire logic clear_status_in,
  input wire logic flags_query_in,
  input wire logic trigger_in,
  input wire logic hold_in,
  input wire logic lockout_in,
  input wire logic go_local_in,
  input wire logic dev_clear_in,
  // Watched outputs.
  input wire logic [7:0] event_flags_reg_out,
  input wire logic [7:0] event_flags_mask_out,
  input wire logic [7:0] status_byte_out,
  input wire logic measure_start_out,
  input wire logic keys_enabled_out,
  input wire logic local_key_enabled_out,
  input wire logic input_flush_out,
  input wire logic discard_input_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Short alias for the flag byte.
  logic [7:0] f;
  assign f = event_flags_reg_out;
  logic clr;
  assign clr = clear_status_in | flags_query_in;
  // One measurement pulse and then quiet.
  sequence s_meas_once;
    measure_start_out ##1 !measure_start_out;
  endsequence
  property p_no_ctrl; f[6] == 1'b0 && f[1] == 1'b0; endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("reserved flag set");
  property p_sum; status_byte_out[5] == $past(|(f & event_flags_mask_out)); endproperty
  a_sum: assert property (p_sum) else $error("event summary wrong");
  property p_range; range_error_in |=> f[4]; endproperty
  a_range: assert property (p_range) else $error("exec flag missing");
  property p_syn; syntax_error_in |=> f[5] && discard_input_out; endproperty
  a_syn: assert property (p_syn) else $error("syntax flag missing");
  property p_fault; device_fault_in |=> f[3]; endproperty
  a_fault: assert property (p_fault) else $error("fault flag missing");
  property p_pwr; power_restore_in |=> f[7]; endproperty
  a_pwr: assert property (p_pwr) else $error("power flag missing");
  property p_clr;
    clr && !(syntax_error_in | range_error_in | device_fault_in | power_restore_in | trigger_in)
      |=> (f & 8'hb8) == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("flags not cleared");
  property p_sticky; f[4] && !clr |=> f[4]; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_trig; trigger_in && hold_in |=> s_meas_once; endproperty
  a_trig: assert property (p_trig) else $error("held trigger wrong");
  property p_notrig; trigger_in && !hold_in |=> !measure_start_out && f[4]; endproperty
  a_notrig: assert property (p_notrig) else $error("free trigger wrong");
  property p_lock;
    lockout_in && !go_local_in |=> !keys_enabled_out && !local_key_enabled_out;
  endproperty
  a_lock: assert property (p_lock) else $error("keys not locked");
  property p_dcl; dev_clear_in |=> input_flush_out; endproperty
  a_dcl: assert property (p_dcl) else $error("no input flush");
endmodule : gesu_event_monitor

`default_nettype wire

/* verification/gesu_ctrl_model.sv */
// Bus controller model that turns a command code into a one-cycle command strobe.
`timescale 1ns/1ps
`default_nettype none

module gesu_ctrl_model
(
  // Clock.
  input wire logic clk_in,
  // Command request.
  input wire logic [2:0] cmd_in,
  input wire logic go_in,
  // One-hot strobes: local, lockout, remote, clear, trigger, poll, cls, query.
  output logic [7:0] cmd_out
);
  // Flags are cleared when read by query, as by clear status.
  always_ff @(posedge clk_in)
  begin
    cmd_out <= go_in ? (8'h01 << cmd_in) : 8'h00;
  end
endmodule : gesu_ctrl_model

`default_nettype wire

/* verification/tb_top.sv */
// Self-checking testbench of the event status unit.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import gesu_pkg::*;
  typedef struct packed {logic [2:0] ev; logic [7:0] m, f, s;} gesu_row_s;
  logic clk_in, rst_n_in, go, hold, idle, meas, flush, keys, lkey, sreq, disc;
  logic [15:0] p;
  logic [7:0] wd, fl, msk, srm, sb, c;
  logic [2:0] cq;
  int err_total, checked, nm, nf;
  gesu_row_s rows [5] = '{'{3'h1, 8'h10, 8'h10, 8'h20}, '{3'h1, 8'hef, 8'h10, 8'h00},
    '{3'h2, 8'h20, 8'h20, 8'h20}, '{3'h4, 8'h08, 8'h08, 8'h20}, '{3'h7, 8'h00, 8'h38, 8'h00}};
  gesu_ctrl_model u_ctl (.clk_in(clk_in), .cmd_in(cq), .go_in(go), .cmd_out(c));
  gesu_event_unit u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .power_restore_in(p[3]),
    .syntax_error_in(p[1]), .terminator_in(p[5]), .range_error_in(p[0]),
    .device_fault_in(p[2]), .op_complete_req_in(p[4]), .actions_idle_in(idle),
    .clear_status_in(c[6]), .flags_query_in(c[7]), .flags_mask_write_in(p[10]),
    .srq_mask_write_in(p[11]), .write_data_in(wd), .resp_push_in(p[6]), .resp_pop_in(p[7]),
    .new_msg_in(p[8]), .idn_extra_query_in(p[9]), .go_local_in(c[0]), .remote_in(c[2]),
    .lockout_in(c[1]), .dev_clear_in(c[3]), .trigger_in(c[4]), .hold_in(hold),
    .serial_poll_in(c[5]), .event_flags_reg_out(fl), .event_flags_mask_out(msk),
    .service_request_mask_out(srm), .status_byte_out(sb), .service_request_out(sreq),
    .discard_input_out(disc), .input_flush_out(flush), .measure_start_out(meas),
    .keys_enabled_out(keys), .local_key_enabled_out(lkey));
  // Clock of 8 ns.
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Compare and count.
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Wait n edges, then step past the edge so outputs have settled.
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  // Pulse tb-driven strobes for one cycle.
  task pul(input logic [15:0] v, input logic [7:0] d);
    @(posedge clk_in);
    p <= v;
    wd <= d;
    @(posedge clk_in);
    p <= 16'h0000;
  endtask : pul
  // Ask the controller model for one command.
  task cmd(input logic [2:0] k);
    @(posedge clk_in);
    cq <= k;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
  endtask : cmd
  // Count output pulses over a bounded stretch.
  task cnt;
    nm = 0;
    nf = 0;
    repeat (6)
    begin
      @(posedge clk_in);
      #1;
      if (meas === 1'b1) nm++;
      if (flush === 1'b1) nf++;
    end
  endtask : cnt
  task test_done;
    $display("TB: %0d checks, %0d errors", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done
  // Main sequence.
  initial
  begin
    rst_n_in = 1'b0;
    {p, wd, cq, go, hold, idle, err_total, checked} = '0;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(1);
    chk(fl, FLAGS_RESET);
    chk({msk[5:0], keys, lkey}, 8'h03);
    foreach (rows[i])
    begin
      cmd(3'd6);
      pul(16'h0400, rows[i].m);
      pul({13'h0, rows[i].ev}, 8'h00);
      tick(3);
      chk(fl, rows[i].f);
      chk(sb & 8'h20, rows[i].s);
    end
    $display("TB: rows done");
    chk({7'h00, disc}, 8'h01);
    pul(16'h0020, 8'h00);
    tick(1);
    chk({7'h00, disc}, 8'h00);
    cmd(3'd7);
    tick(3);
    chk(fl, 8'h00);
    pul(16'h0008, 8'h00);
    tick(2);
    chk(fl, 8'h80);
    pul(16'h0010, 8'h00);
    tick(2);
    chk(fl & 8'h01, 8'h00);
    @(posedge clk_in) idle <= 1'b1;
    tick(2);
    chk(fl & 8'h01, 8'h01);
    cmd(3'd6);
    @(posedge clk_in) hold <= 1'b1;
    cmd(3'd4);
    cnt();
    chk(8'(nm), 8'h01);
    @(posedge clk_in) hold <= 1'b0;
    cmd(3'd4);
    cnt();
    chk({8'(nm)}, 8'h00);
    chk(fl & 8'h10, 8'h10);
    $display("TB: trigger done");
    pul(16'h0040, 8'h00);
    tick(3);
    chk(sb & 8'h10, 8'h10);
    cmd(3'd3);
    cnt();
    chk(8'(nf), 8'h01);
    chk(sb & 8'h10, 8'h00);
    pul(16'h0080, 8'h00);
    tick(3);
    chk(fl & 8'h04, 8'h04);
    pul(16'h0800, 8'h20);
    pul(16'h0400, 8'h04);
    tick(3);
    chk(sb & 8'h60, 8'h60);
    chk({7'h00, sreq}, 8'h01);
    chk(srm, 8'h20);
    cmd(3'd5);
    cmd(3'd1);
    tick(3);
    chk({6'h00, keys, lkey}, 8'h00);
    chk({7'h00, sreq}, 8'h00);
    cmd(3'd0);
    tick(3);
    chk({7'h00, keys}, 8'h01);
    cmd(3'd2);
    tick(3);
    chk({6'h00, keys, lkey}, 8'h01);
    cmd(3'd0);
    tick(3);
    chk({6'h00, keys, lkey}, 8'h03);
    $display("TB: panel done");
    @(posedge clk_in) rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    tick(1);
    chk(fl, FLAGS_RESET);
    chk(msk | srm | sb, 8'h00);
    chk({6'h00, keys, sreq}, 8'h02);
    $display("TB: reset done");
    test_done();
  end
endmodule : tb_top

bind gesu_event_unit gesu_event_monitor u_mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .syntax_error_in(syntax_error_in), .range_error_in(range_error_in),
  .device_fault_in(device_fault_in), .power_restore_in(power_restore_in),
  .clear_status_in(clear_status_in), .flags_query_in(flags_query_in),
  .trigger_in(trigger_in), .hold_in(hold_in), .lockout_in(lockout_in),
  .go_local_in(go_local_in), .dev_clear_in(dev_clear_in),
  .event_flags_reg_out(event_flags_reg_out), .event_flags_mask_out(event_flags_mask_out),
  .status_byte_out(status_byte_out), .measure_start_out(measure_start_out),
  .keys_enabled_out(keys_enabled_out), .local_key_enabled_out(local_key_enabled_out),
  .input_flush_out(input_flush_out), .discard_input_out(discard_input_out));

`default_nettype wire
